// *** hw/rsic_ctrl.sv ***
// radio strobe interpreter, event flags and interrupt requests with wishbone slave
//
// Chosen here: the Wishbone interface to the registers and the address map.
`default_nettype none
module rsic_ctrl #(
   parameter int QDEPTH = 4
) (
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   input  wire logic                     ce_i,
   // wishbone classic slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   output logic                          wb_err_o,
   // radio datapath
   input  wire rsic_pkg::rsic_radio_in_t radio_i,
   output rsic_pkg::rsic_radio_out_t     radio_o,
   output logic [2:0]                    radio_state_o,
   // interrupt requests: vector 0 data transfer, vector 16 general radio
   output logic                          irq_xfer_o,
   output logic                          irq_radio_o
);
   import rsic_pkg::*;

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   rsic_state_t state_ff;
   rsic_state_t nxt_state;
   rsic_state_t target_ff;
   rsic_state_t nxt_target;
   logic [7:0]  timer_ff;
   logic [7:0]  nxt_timer;
   logic        cal_off_ff;                // switch synthesizer off after calibration
   logic        nxt_cal_off;

   logic [7:0]  evt_flag_ff;
   logic [7:0]  evt_mask_ff;
   logic [7:0]  evt_prev_ff;
   logic        xfer_flag_ff;
   logic        radio_flag_ff;

   logic        xfer_en_ff;
   logic        radio_en_ff;
   logic [7:0]  sm_cfg0_ff;

   logic        tx_armed_ff;
   logic [7:0]  tx_byte_ff;
   logic        tx_valid_ff;

   logic        idle_drain_ff;

   logic        ack_ff;
   logic        err_ff;
   logic [31:0] rdata_ff;

   // ------------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------------
   logic        req;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        lane0;
   logic        wr_strobe;
   logic        wr_data;
   logic        wr_flag;
   logic        wr_mask;
   logic        wr_cpu;
   logic        wr_en;
   logic        wr_cfg;
   logic        rd_data;
   assign req    = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
   assign lane0  = wb_sel_i[0];
   assign wr     = req && wb_we_i && ce_i;
   assign rd     = req && !wb_we_i && ce_i;
   always_comb begin
      unique case (wb_adr_i)
         OFS_STROBE, OFS_DATA, OFS_EVT_FLAG, OFS_EVT_MASK,
         OFS_CPU_FLAG, OFS_IRQ_EN, OFS_SM_CFG0, OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign wr_strobe = wr && lane0 && wb_adr_i == OFS_STROBE;
   assign wr_data   = wr && lane0 && wb_adr_i == OFS_DATA;
   assign wr_flag   = wr && lane0 && wb_adr_i == OFS_EVT_FLAG;
   assign wr_mask   = wr && lane0 && wb_adr_i == OFS_EVT_MASK;
   assign wr_cpu    = wr && lane0 && wb_adr_i == OFS_CPU_FLAG;
   assign wr_en     = wr && lane0 && wb_adr_i == OFS_IRQ_EN;
   assign wr_cfg    = wr && lane0 && wb_adr_i == OFS_SM_CFG0;
   assign rd_data   = rd && wb_adr_i == OFS_DATA;

   // one-cycle ack, error for unmapped addresses
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else if (ce_i) begin
         ack_ff <= req && mapped;
         err_ff <= req && !mapped;
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;

   // read mux, status reflects live radio state
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_ff <= '0;
      end else if (rd) begin
         unique case (wb_adr_i)
            OFS_DATA:     rdata_ff <= {24'h0, radio_i.rx_byte};
            OFS_EVT_FLAG: rdata_ff <= {24'h0, evt_flag_ff};
            OFS_EVT_MASK: rdata_ff <= {24'h0, evt_mask_ff};
            OFS_CPU_FLAG: rdata_ff <= {30'h0, radio_flag_ff, xfer_flag_ff};
            OFS_IRQ_EN:   rdata_ff <= {30'h0, radio_en_ff, xfer_en_ff};
            OFS_SM_CFG0:  rdata_ff <= {24'h0, sm_cfg0_ff};
            OFS_STATUS:   rdata_ff <= {27'h0, radio_i.channel_clear,
                                       1'b0, state_ff};
            default:      rdata_ff <= '0;
         endcase
      end
   end
   assign wb_dat_o = rdata_ff;

   // ------------------------------------------------------------------------
   // strobe queue
   // ------------------------------------------------------------------------
   logic       is_idle_stb;
   logic       q_valid;
   logic       q_pop;
   logic       q_push;
   logic       busy;
   logic [7:0] q_code;
   assign is_idle_stb = wr_strobe && wb_dat_i[7:0] == STB_GO_IDLE;
   assign busy   = state_ff == RS_CAL || state_ff == RS_SETTLE;
   // strobes behind an idle strobe are ignored until idle is reached
   assign q_push = wr_strobe && !is_idle_stb && !idle_drain_ff;
   assign q_pop  = ce_i && q_valid && !busy;

   rsic_strobe_queue #(.DEPTH(QDEPTH)) u_queue (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .ce_i    (ce_i),
      .flush_i (is_idle_stb),
      .push_i  (q_push),
      .code_i  (wb_dat_i[7:0]),
      .pop_i   (q_pop),
      .valid_o (q_valid),
      .code_o  (q_code)
   );

   // idle drain window lasts until the idle state is in force
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         idle_drain_ff <= 1'b0;
      end else if (ce_i) begin
         if (is_idle_stb) begin
            idle_drain_ff <= 1'b1;
         end else if (state_ff == RS_IDLE) begin
            idle_drain_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------------
   // radio state machine
   // ------------------------------------------------------------------------
   logic [1:0] cal_mode;
   logic       cca_en;
   assign cal_mode = sm_cfg0_ff[CFG_CAL_LSB +: 2];
   assign cca_en   = sm_cfg0_ff[CFG_CCA_BIT];

   always_comb begin
      nxt_state   = state_ff;
      nxt_target  = target_ff;
      nxt_timer   = timer_ff;
      nxt_cal_off = cal_off_ff;
      if (is_idle_stb) begin
         nxt_state = RS_IDLE;
      end else if (busy) begin
         if (timer_ff != 8'h00) begin
            nxt_timer = timer_ff - 8'h01;
         end else if (state_ff == RS_CAL) begin
            nxt_state = cal_off_ff ? RS_IDLE : RS_SETTLE;
            nxt_timer = SETTLE_CYC;
         end else begin
            nxt_state = target_ff;
         end
      end else if (q_valid) begin
         nxt_cal_off = 1'b0;
         unique case (q_code)
            STB_SYNTH_ON: begin
               nxt_target = RS_FS_ON;
               nxt_timer  = (state_ff == RS_IDLE && cal_mode == CAL_FROM_IDLE)
                            ? CAL_CYC : SETTLE_CYC;
               nxt_state  = (state_ff == RS_IDLE && cal_mode == CAL_FROM_IDLE)
                            ? RS_CAL : RS_SETTLE;
            end
            STB_CALIBRATE: begin
               if (state_ff == RS_IDLE || state_ff == RS_FS_ON) begin
                  nxt_state   = RS_CAL;
                  nxt_timer   = CAL_CYC;
                  nxt_cal_off = 1'b1;
               end
            end
            STB_RECEIVE: begin
               nxt_target = RS_RX;
               if (state_ff == RS_IDLE && cal_mode == CAL_FROM_IDLE) begin
                  nxt_state = RS_CAL;
                  nxt_timer = CAL_CYC;
               end else if (state_ff != RS_RX) begin
                  nxt_state = RS_SETTLE;
                  nxt_timer = SETTLE_CYC;
               end
            end
            STB_TRANSMIT: begin
               nxt_target = RS_TX;
               if (state_ff == RS_RX && cca_en && !radio_i.channel_clear) begin
                  nxt_state = RS_RX;
               end else if (state_ff == RS_IDLE && cal_mode == CAL_FROM_IDLE) begin
                  nxt_state = RS_CAL;
                  nxt_timer = CAL_CYC;
               end else if (state_ff != RS_TX) begin
                  nxt_state = RS_SETTLE;
                  nxt_timer = SETTLE_CYC;
               end
            end
            default: begin
               nxt_state = state_ff;
            end
         endcase
      end
   end

   // state registers; the one reference clock drives all state
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_ff   <= RS_IDLE;
         target_ff  <= RS_IDLE;
         timer_ff   <= 8'h00;
         cal_off_ff <= 1'b0;
      end else if (ce_i) begin
         state_ff   <= nxt_state;
         target_ff  <= nxt_target;
         timer_ff   <= nxt_timer;
         cal_off_ff <= nxt_cal_off;
      end
   end

   // synthesizer runs in every state but idle
   assign radio_state_o       = state_ff;
   assign radio_o.synth_en    = state_ff != RS_IDLE;
   assign radio_o.cal_active  = state_ff == RS_CAL;
   assign radio_o.rx_en       = state_ff == RS_RX;
   assign radio_o.tx_en       = state_ff == RS_TX;
   assign radio_o.tx_byte_valid = tx_valid_ff;
   assign radio_o.tx_byte     = tx_byte_ff;

   // ------------------------------------------------------------------------
   // configuration and transmit data
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sm_cfg0_ff  <= RST_SM_CFG0;
         evt_mask_ff <= 8'h00;
         xfer_en_ff  <= 1'b0;
         radio_en_ff <= 1'b0;
      end else if (ce_i) begin
         if (wr_cfg)  sm_cfg0_ff  <= wb_dat_i[7:0];
         if (wr_mask) evt_mask_ff <= wb_dat_i[7:0];
         if (wr_en) begin
            xfer_en_ff  <= wb_dat_i[EN_XFER_BIT];
            radio_en_ff <= wb_dat_i[EN_RADIO_BIT];
         end
      end
   end

   // transmit byte hand-off; armed only by a transmit strobe
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         tx_armed_ff <= 1'b0;
         tx_byte_ff  <= 8'h00;
         tx_valid_ff <= 1'b0;
      end else if (ce_i) begin
         if (wr_strobe && wb_dat_i[7:0] == STB_TRANSMIT) begin
            tx_armed_ff <= 1'b1;
         end else if (is_idle_stb) begin
            // disarming on the idle state instead would lose a transmit
            // strobe that is still waiting in the queue while idle
            tx_armed_ff <= 1'b0;
         end
         if (wr_data) begin
            tx_byte_ff  <= wb_dat_i[7:0];
         end
         tx_valid_ff <= wr_data;
      end
   end

   // ------------------------------------------------------------------------
   // flags and interrupts
   // ------------------------------------------------------------------------
   logic [7:0] evt_rise;
   logic       xfer_set;
   logic       radio_set;
   assign evt_rise  = radio_i.event_pulse & ~evt_prev_ff;
   assign xfer_set  = (radio_i.rx_byte_ready && state_ff == RS_RX)
                    || (radio_i.tx_byte_space && tx_armed_ff && state_ff == RS_TX);
   assign radio_set = |(evt_rise & evt_mask_ff);

   // sticky flags, set wins over software clear (write 0 clears)
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         evt_prev_ff   <= 8'h00;
         evt_flag_ff   <= 8'h00;
         xfer_flag_ff  <= 1'b0;
         radio_flag_ff <= 1'b0;
      end else if (ce_i) begin
         evt_prev_ff <= radio_i.event_pulse;
         evt_flag_ff <= (wr_flag ? (evt_flag_ff & wb_dat_i[7:0]) : evt_flag_ff)
                        | evt_rise;
         if (xfer_set) begin
            xfer_flag_ff <= 1'b1;
         end else if (wr_cpu || rd_data) begin
            xfer_flag_ff <= wr_cpu ? (xfer_flag_ff & wb_dat_i[CPU_XFER_BIT]) : 1'b0;
         end
         if (radio_set) begin
            radio_flag_ff <= 1'b1;
         end else if (wr_cpu) begin
            radio_flag_ff <= radio_flag_ff & wb_dat_i[CPU_RADIO_BIT];
         end
      end
   end

   assign irq_xfer_o  = xfer_flag_ff && xfer_en_ff;
   assign irq_radio_o = radio_flag_ff && radio_en_ff;
endmodule : rsic_ctrl
`default_nettype wire

// *** hw/rsic_strobe_queue.sv ***
// small in-order queue of pending strobe codes
`default_nettype none
module rsic_strobe_queue #(
   parameter int DEPTH = 4
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   input  wire logic       flush_i,
   input  wire logic       push_i,
   input  wire logic [7:0] code_i,
   input  wire logic       pop_i,
   output logic            valid_o,
   output logic [7:0]      code_o
);
   import rsic_pkg::*;
   localparam int AW = $clog2(DEPTH);
   logic [7:0]  mem_ff [DEPTH];
   logic [AW:0] wr_ff;
   logic [AW:0] rd_ff;
   logic        full;

   assign valid_o = (wr_ff != rd_ff);
   assign full    = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
   assign code_o  = mem_ff[rd_ff[AW-1:0]];

   // pointers; a write into a full queue is dropped
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else if (ce_i) begin
         if (flush_i) begin
            rd_ff <= wr_ff;
         end else begin
            if (push_i && !full) begin
               wr_ff <= wr_ff + 1'b1;
            end
            if (pop_i && valid_o) begin
               rd_ff <= rd_ff + 1'b1;
            end
         end
      end
   end

   // storage
   always_ff @(posedge clk_i) begin
      if (ce_i && push_i && !full && !flush_i) begin
         mem_ff[wr_ff[AW-1:0]] <= code_i;
      end
   end
endmodule : rsic_strobe_queue
`default_nettype wire

// *** include/rsic_pkg.sv ***
// package of constants and types for the radio strobe and interrupt control block
// ---------------------------------------------------------------------------
// Notes on behaviour
// - synth-on strobe enables, calibrates, or waits from receive
// - calibrate strobe calibrates, then synthesizer off
// - receive strobe enters receive, calibrating from idle
// - transmit strobe from idle enters transmit, calibrating
// - transmit from receive with assessment needs clear channel
// - idle strobe stops synthesizer; unknown codes do nothing
// - idle strobe discards pending strobes until idle
// - each defined strobe byte starts one of five sequences
// - two interrupt lines: data transfer and general radio
// - general interrupt combines masked event sources
// - general interrupt fires on rising event edges only
// - data flag set on receive byte or transmit space
// - transmit data flag only after transmit strobe
// - data register plus configuration registers on the bus
// - reference clock is crystal, halved in usb variant
// - registers also return live radio status
// - data interrupt needs flag and enable bit
// - eight events set flags; masked ones set cpu flag
// - cpu flag with enable raises the radio interrupt
// ---------------------------------------------------------------------------
`default_nettype none
package rsic_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_STROBE     = 8'h00;
   localparam logic [7:0] OFS_DATA       = 8'h04;
   localparam logic [7:0] OFS_EVT_FLAG   = 8'h08;
   localparam logic [7:0] OFS_EVT_MASK   = 8'h0c;
   localparam logic [7:0] OFS_CPU_FLAG   = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN     = 8'h14;
   localparam logic [7:0] OFS_SM_CFG0    = 8'h18;
   localparam logic [7:0] OFS_STATUS     = 8'h1c;
   // strobe codes
   localparam logic [7:0] STB_SYNTH_ON   = 8'h00;
   localparam logic [7:0] STB_CALIBRATE  = 8'h01;
   localparam logic [7:0] STB_RECEIVE    = 8'h02;
   localparam logic [7:0] STB_TRANSMIT   = 8'h03;
   localparam logic [7:0] STB_GO_IDLE    = 8'h04;
   // calibration mode field values
   localparam logic [1:0] CAL_MANUAL     = 2'h0;
   localparam logic [1:0] CAL_FROM_IDLE  = 2'h1;
   // field positions
   localparam int CFG_CAL_LSB   = 4;   // calibration mode in config0 [5:4]
   localparam int CFG_CCA_BIT   = 0;   // clear channel assessment enable
   localparam int CPU_XFER_BIT  = 0;   // data transfer flag
   localparam int CPU_RADIO_BIT = 1;   // cpu radio interrupt flag
   localparam int EN_XFER_BIT   = 0;
   localparam int EN_RADIO_BIT  = 1;
   localparam int N_EVENTS      = 8;
   // reset values
   localparam logic [7:0] RST_SM_CFG0 = 8'h10;
   // timing: calibration and settling
   localparam int CAL_TIME_NS    = 720;
   localparam int SETTLE_TIME_NS = 88;
   localparam int CLK_PERIOD_NS  = 8;
   localparam logic [7:0] CAL_CYC    = 8'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int QUEUE_DEPTH = 4;

   typedef enum logic [2:0] {
      RS_IDLE, RS_CAL, RS_SETTLE, RS_FS_ON, RS_RX, RS_TX
   } rsic_state_t;

   // events from the radio datapath
   typedef struct packed {
      logic [7:0] event_pulse;  // underflow .. sync word
      logic       rx_byte_ready;
      logic       tx_byte_space;
      logic       channel_clear;
      logic [7:0] rx_byte;
   } rsic_radio_in_t;

   // controls toward the radio datapath
   typedef struct packed {
      logic       synth_en;
      logic       cal_active;
      logic       rx_en;
      logic       tx_en;
      logic       tx_byte_valid;
      logic [7:0] tx_byte;
   } rsic_radio_out_t;
endpackage : rsic_pkg
`default_nettype wire

// *** verif/rsic_ctrl_assertions.sv ***
// port-level checker for the radio strobe and interrupt control block
`default_nettype none
module rsic_ctrl_assertions
   import rsic_pkg::*;
#(
   parameter int QDEPTH = 4
) (
   input wire logic                      clk_i,
   input wire logic                      rstn_i,
   input wire logic                      ce_i,
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_we_i,
   input wire logic [7:0]                wb_adr_i,
   input wire logic [3:0]                wb_sel_i,
   input wire logic [31:0]               wb_dat_i,
   input wire logic [31:0]               wb_dat_o,
   input wire logic                      wb_ack_o,
   input wire logic                      wb_err_o,
   input wire rsic_pkg::rsic_radio_in_t  radio_i,
   input wire rsic_pkg::rsic_radio_out_t radio_o,
   input wire logic [2:0]                radio_state_o,
   input wire logic                      irq_xfer_o,
   input wire logic                      irq_radio_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // a new bus request and a byte written to the strobe register
   logic req;
   logic stb_wr;
   assign req    = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
   assign stb_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_STROBE);

   a_bus_answer: assert property (req |=> (wb_ack_o ^ wb_err_o))
      else $error("bus request not answered in one cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_unmapped: assert property (req && wb_adr_i > OFS_STATUS |=> wb_err_o)
      else $error("unmapped address not refused");
   a_idle_quiet: assert property (radio_state_o == 3'd0 |->
      !radio_o.synth_en && !radio_o.rx_en && !radio_o.tx_en)
      else $error("radio active while idle");
   a_rx_enables: assert property (radio_state_o == 3'd4 |->
      radio_o.rx_en && radio_o.synth_en && !radio_o.tx_en)
      else $error("receive enables wrong");
   a_tx_enables: assert property (radio_state_o == 3'd5 |->
      radio_o.tx_en && radio_o.synth_en && !radio_o.rx_en)
      else $error("transmit enables wrong");
   a_cal_marked: assert property (radio_o.cal_active == (radio_state_o == 3'd1))
      else $error("calibration flag disagrees with state");
   a_cal_held: assert property ($rose(radio_state_o == 3'd1) |->
      (radio_state_o == 3'd1) [*8])
      else $error("calibration cut short");
   a_idle_strobe: assert property (stb_wr && wb_dat_i[7:0] == STB_GO_IDLE |=>
      ##[0:1] radio_state_o == 3'd0)
      else $error("idle strobe did not stop the radio");
   a_nop_ignored: assert property (stb_wr && wb_dat_i[7:0] > STB_GO_IDLE
      && radio_state_o == 3'd0 |=> (radio_state_o == 3'd0) [*4])
      else $error("unknown strobe changed state");
   a_tx_handoff: assert property (req && wb_we_i && wb_sel_i[0]
      && wb_adr_i == OFS_DATA |=> radio_o.tx_byte_valid)
      else $error("transmit byte not handed on");
endmodule : rsic_ctrl_assertions
`default_nettype wire

// *** verif/rsic_radio_model.sv ***
// behavioural radio datapath facing the control block
`default_nettype none
module rsic_radio_model
   import rsic_pkg::*;
(
   input  wire logic                      clk_i,
   input  wire rsic_pkg::rsic_radio_out_t ctl_i,
   input  wire logic [7:0]                evt_i,
   input  wire logic                      clear_i,
   output rsic_pkg::rsic_radio_in_t       radio_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial radio_o = '0;

   // byte ready only in receive, space only in transmit; stale data is scrambled
   always @(posedge clk_i) begin
      radio_o.rx_byte_ready <= ctl_i.rx_en;
      radio_o.tx_byte_space <= ctl_i.tx_en;
      radio_o.rx_byte       <= ctl_i.rx_en ? 8'h5a : ~radio_o.rx_byte;
      radio_o.event_pulse   <= evt_i;
      radio_o.channel_clear <= clear_i;
   end
endmodule : rsic_radio_model
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking testbench for the radio strobe and interrupt control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rsic_pkg::*;

   logic            clk = 1'b0, rstn = 1'b0, ce = 1'b1, clr = 1'b1;
   logic            cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, irq_x, irq_r, e;
   logic [7:0]      adr = 8'h00, evt = 8'h00;
   logic [31:0]     dat_w = 32'h0, dat_r, q;
   logic [2:0]      state;
   rsic_radio_in_t  r_in;
   rsic_radio_out_t r_out;
   int              num_errors = 0, n_compared = 0, cycles = 0;

   rsic_ctrl #(.QDEPTH(4)) i_rsic_ctrl (
      .clk_i(clk), .rstn_i(rstn), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_err_o(err), .radio_i(r_in),
      .radio_o(r_out), .radio_state_o(state), .irq_xfer_o(irq_x), .irq_radio_o(irq_r)
   );
   rsic_radio_model i_rsic_radio_model (
      .clk_i(clk), .ctl_i(r_out), .evt_i(evt), .clear_i(clr), .radio_o(r_in)
   );

   // clock and hang guard
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one classic cycle: hold until ack or err is sampled, then release for a cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
      q = dat_r;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wait_state(input logic [2:0] s);
      int n;
      n = 0;
      while (state !== s && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_state

   task automatic t_regs();
      bus(0, OFS_SM_CFG0, 0);
      check(q, 32'h10);
      bus(0, OFS_EVT_MASK, 0);
      check(q, 32'h0);
      bus(0, 8'h20, 0);
      check(32'(e), 32'h1);
   endtask : t_regs

   task automatic t_rx();
      bus(1, OFS_STROBE, STB_RECEIVE);
      wait_state(3'd1);
      check(32'(state), 32'h1);
      wait_state(3'd4);
      check(32'(state), 32'h4);
      bus(0, OFS_DATA, 0);
      check(q, 32'h5a);
      bus(0, OFS_STATUS, 0);
      check(q, 32'h14);
      bus(1, OFS_IRQ_EN, 32'h1);
      check(32'(irq_x), 32'h1);
      bus(1, OFS_IRQ_EN, 32'h0);
      check(32'(irq_x), 32'h0);
      bus(1, OFS_STROBE, STB_GO_IDLE);
      check(32'(state), 32'h0);
      bus(1, OFS_CPU_FLAG, 0);
   endtask : t_rx

   task automatic t_cal();
      bus(1, OFS_STROBE, STB_CALIBRATE);
      wait_state(3'd1);
      check(32'(state), 32'h1);
      wait_state(3'd0);
      check(32'(state), 32'h0);
      bus(1, OFS_STROBE, STB_SYNTH_ON);
      wait_state(3'd1);
      check(32'(state), 32'h1);
      wait_state(3'd3);
      check(32'(state), 32'h3);
      bus(1, OFS_STROBE, STB_GO_IDLE);
   endtask : t_cal

   task automatic t_tx();
      bus(1, OFS_IRQ_EN, 32'h1);
      check(32'(irq_x), 32'h0);
      bus(1, OFS_STROBE, STB_TRANSMIT);
      wait_state(3'd1);
      check(32'(state), 32'h1);
      wait_state(3'd5);
      repeat (3) @(posedge clk);
      check(32'(irq_x), 32'h1);
      bus(1, OFS_DATA, 32'ha5); // data only after the strobe
      check(32'(r_out.tx_byte), 32'ha5);
      bus(1, OFS_STROBE, STB_GO_IDLE);
      bus(1, OFS_IRQ_EN, 0);
      bus(1, OFS_CPU_FLAG, 0);
   endtask : t_tx

   task automatic t_queue();
      bus(1, OFS_STROBE, STB_RECEIVE);
      bus(1, OFS_STROBE, STB_SYNTH_ON);
      wait_state(3'd4);
      check(32'(state), 32'h4);
      wait_state(3'd3);
      check(32'(state), 32'h3);
      bus(1, OFS_STROBE, STB_GO_IDLE);
   endtask : t_queue

   task automatic t_cca();
      bus(1, OFS_SM_CFG0, 32'h11);
      bus(1, OFS_STROBE, STB_RECEIVE);
      clr <= 1'b0;
      wait_state(3'd4);
      bus(1, OFS_STROBE, STB_TRANSMIT);
      repeat (20) @(posedge clk);
      check(32'(state), 32'h4);
      clr <= 1'b1;
      repeat (2) @(posedge clk);
      bus(1, OFS_STROBE, STB_TRANSMIT);
      wait_state(3'd5);
      check(32'(state), 32'h5);
      bus(1, OFS_STROBE, STB_GO_IDLE);
      bus(1, OFS_SM_CFG0, 32'h10);
   endtask : t_cca

   task automatic t_flush();
      logic [7:0] codes [3] = '{8'h05, 8'h7f, 8'hff};
      bus(1, OFS_STROBE, STB_RECEIVE);
      repeat (20) @(posedge clk);
      bus(1, OFS_STROBE, STB_TRANSMIT);
      bus(1, OFS_STROBE, STB_GO_IDLE);
      repeat (150) @(posedge clk);
      check(32'(state), 32'h0);
      foreach (codes[i]) begin
         bus(1, OFS_STROBE, codes[i]);
         repeat (5) @(posedge clk);
         check(32'(state), 32'h0);
      end
   endtask : t_flush

   task automatic t_events();
      bus(1, OFS_EVT_MASK, 32'h01);
      bus(1, OFS_IRQ_EN, 32'h2);
      evt <= 8'h01;
      repeat (4) @(posedge clk);
      check(32'(irq_r), 32'h1);
      bus(0, OFS_EVT_FLAG, 0);
      check(q, 32'h01);
      bus(1, OFS_CPU_FLAG, 0);
      bus(1, OFS_EVT_FLAG, 0);
      repeat (4) @(posedge clk);
      check(32'(irq_r), 32'h0);
      evt <= 8'h81;
      repeat (4) @(posedge clk);
      bus(0, OFS_EVT_FLAG, 0);
      check(q, 32'h80);
      check(32'(irq_r), 32'h0);
      evt <= 8'h00;
      @(posedge clk);
      evt <= 8'h01;
      repeat (4) @(posedge clk);
      check(32'(irq_r), 32'h1);
   endtask : t_events

   task automatic t_freeze();
      bus(1, OFS_STROBE, STB_CALIBRATE);
      ce <= 1'b0;
      repeat (200) @(posedge clk);
      check(32'(state), 32'h1);
      ce <= 1'b1;
      wait_state(3'd0);
      check(32'(state), 32'h0);
   endtask : t_freeze

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // main sequence after reset
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_rx();
      t_cal();
      t_freeze();
      t_tx();
      t_queue();
      t_cca();
      t_flush();
      t_events();
      final_report();
   end
endmodule : testbench

bind rsic_ctrl rsic_ctrl_assertions #(.QDEPTH(QDEPTH)) i_rsic_ctrl_assertions (
   .clk_i, .rstn_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .radio_i, .radio_o, .radio_state_o,
   .irq_xfer_o, .irq_radio_o
);
`default_nettype wire
